// *** rtl/smd_pkg.sv ***
/*
 * Shared constants of the sequential multiply/divide unit: register map,
 * field positions, reset values and operation lengths.
 * Assumes a 32-bit classic Wishbone slave port with byte addressing.
 */
package smd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_OPERAND_A = 8'h00;
    localparam logic [7:0] OFS_OPERAND_B = 8'h04;
    localparam logic [7:0] OFS_REMAINDER = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    // Control register fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 7;
    // Status and mask fields
    localparam int STAT_DONE_BIT = 0;
    // Reset values
    localparam logic [31:0] RST_OPERAND_A = 32'h0000_0000;
    localparam logic [15:0] RST_OPERAND_B = 16'h0000;
    localparam logic [15:0] RST_REMAINDER = 16'h0000;
    localparam logic RST_MODE = 1'b0;
    localparam logic [0:0] RST_IRQ_BITS = 1'h0;
    // Internal clocks per operation
    localparam logic [5:0] MUL_CYCLES = 6'h10;
    localparam logic [5:0] DIV_CYCLES = 6'h20;
endpackage : smd_pkg

// *** rtl/smd_mul_div_unit.sv ***
/*
 * Sequential 16x16 multiplier and 32/16 divider with a Wishbone register
 * file and a maskable end-of-operation interrupt.
 * Assumes a single clock, synchronous active-low reset and a classic
 * Wishbone master that holds each request until it samples ack.
 */
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1 - Multiply: software loads A low word and B, then writes mode and enable.
// RL2 - A multiplication finishes exactly 16 internal clocks after its start.
// RL3 - Both A halves hold intermediate data while a multiplication runs.
// RL4 - After a multiplication the full product sits in the A register.
// RL5 - The enable bit clears itself when either operation ends.
// RL6 - Each completed operation raises the end-of-operation interrupt request.
// RL7 - Divide: software loads dividend in A and divisor in B, mode 0, enable 1.
// RL8 - A division finishes exactly 32 internal clocks after its start.
// RL9 - A halves and remainder hold intermediate data while a division runs.
// RL10 - After a division A holds the quotient, remainder register the remainder.
// RL11 - Every new operation needs operands and control written again.
// RL12 - Starting a multiplication clears the upper half of the A register.
// RL13 - Starting any operation clears the remainder register.
// RL14 - Writing enable as zero during an operation aborts it.
// RL15 - A cycle counter times the operation; done pulse coincides with enable clear.
// RL16 - Reset clears operands, remainder and control, abandoning any operation.
module smd_mul_div_unit import smd_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Events
    output logic arith_done_irq,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] operand_a_result_ff, nxt_operand_a_result;
    logic [15:0] operand_b_ff, nxt_operand_b;
    logic [15:0] remainder_reg_ff, nxt_remainder_reg;
    logic mul_not_div_select_ff, nxt_mul_not_div_select;
    logic arith_run_enable_ff, nxt_arith_run_enable;
    logic [5:0] cnt_ff, nxt_cnt;
    logic done_ff, nxt_done;
    logic [0:0] stat_ff, nxt_stat;
    logic [0:0] mask_ff, nxt_mask;
    logic ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic irq_ff, nxt_irq;
    logic req, wr, rd, abort;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign abort = wr && wb_adr_i == OFS_CONTROL && wb_sel_i[0] && arith_run_enable_ff
        && !wb_dat_i[CTRL_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [16:0] sum;
        logic [16:0] part;
        logic [31:0] tmp;
        sum = 17'h0;
        part = 17'h0;
        tmp = 32'h0;
        nxt_operand_a_result = operand_a_result_ff;
        nxt_operand_b = operand_b_ff;
        nxt_remainder_reg = remainder_reg_ff;
        nxt_mul_not_div_select = mul_not_div_select_ff;
        nxt_arith_run_enable = arith_run_enable_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        nxt_mask = mask_ff;
        nxt_ack = req;
        nxt_dat = dat_ff;

        // One step per clock; A, and in a division also remainder, hold partial data meanwhile [RL3] [RL9]
        if (arith_run_enable_ff) begin
            if (mul_not_div_select_ff) begin
                // Shift-add: product builds up from the top half downward [RL4]
                sum = {1'b0, operand_a_result_ff[31:16]}
                    + (operand_a_result_ff[0] ? {1'b0, operand_b_ff} : 17'h0);
                nxt_operand_a_result = {sum, operand_a_result_ff[15:1]};
            end else begin
                // Restoring division, quotient bits shift into A [RL10]
                part = {remainder_reg_ff, operand_a_result_ff[31]};
                if (part >= {1'b0, operand_b_ff}) begin
                    sum = part - {1'b0, operand_b_ff};
                    nxt_remainder_reg = sum[15:0];
                    nxt_operand_a_result = {operand_a_result_ff[30:0], 1'b1};
                end else begin
                    nxt_remainder_reg = part[15:0];
                    nxt_operand_a_result = {operand_a_result_ff[30:0], 1'b0};
                end
            end
            nxt_cnt = cnt_ff - 6'h01; // [RL15]
            if (cnt_ff == 6'h01) begin
                nxt_arith_run_enable = 1'b0; // [RL5]
                nxt_done = 1'b1; // [RL6] [RL15]
            end
        end

        // Operand writes are dropped while busy so a stray store cannot corrupt a run
        if (wr) begin
            unique case (wb_adr_i)
                OFS_OPERAND_A: begin
                    if (!arith_run_enable_ff) begin
                        nxt_operand_a_result = merge(operand_a_result_ff, wb_dat_i, wb_sel_i);
                    end
                end
                OFS_OPERAND_B: begin
                    if (!arith_run_enable_ff) begin
                        tmp = merge({16'h0, operand_b_ff}, wb_dat_i, wb_sel_i);
                        nxt_operand_b = tmp[15:0];
                    end
                end
                OFS_CONTROL: begin
                    if (!wb_sel_i[0]) begin
                        nxt_cnt = nxt_cnt;
                    end else if (abort) begin
                        nxt_arith_run_enable = 1'b0; // [RL14]
                        nxt_done = 1'b0;
                    end else if (!arith_run_enable_ff && wb_dat_i[CTRL_ENABLE_BIT]) begin
                        nxt_mul_not_div_select = wb_dat_i[CTRL_MODE_BIT];
                        nxt_arith_run_enable = 1'b1;
                        nxt_remainder_reg = RST_REMAINDER; // [RL13]
                        if (wb_dat_i[CTRL_MODE_BIT]) begin
                            nxt_cnt = MUL_CYCLES; // [RL2]
                            nxt_operand_a_result[31:16] = 16'h0000; // [RL12]
                        end else begin
                            nxt_cnt = DIV_CYCLES; // [RL8]
                        end
                    end else if (!arith_run_enable_ff) begin
                        nxt_mul_not_div_select = wb_dat_i[CTRL_MODE_BIT];
                    end
                end
                OFS_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        nxt_mask = wb_dat_i[0:0];
                    end
                end
                default: begin
                    nxt_dat = dat_ff;
                end
            endcase
        end

        // Unmapped addresses still ack and read zero so the master never hangs
        if (rd) begin
            unique case (wb_adr_i)
                OFS_OPERAND_A: nxt_dat = operand_a_result_ff;
                OFS_OPERAND_B: nxt_dat = {16'h0, operand_b_ff};
                OFS_REMAINDER: nxt_dat = {16'h0, remainder_reg_ff};
                OFS_CONTROL: nxt_dat = {24'h0, arith_run_enable_ff, 6'h00, mul_not_div_select_ff};
                OFS_IRQ_STATUS: nxt_dat = {31'h0, stat_ff};
                OFS_IRQ_MASK: nxt_dat = {31'h0, mask_ff};
                default: nxt_dat = 32'h0;
            endcase
        end

        // Read clears status; a done in the same cycle still sets it [RL6]
        nxt_stat = (rd && wb_adr_i == OFS_IRQ_STATUS) ? RST_IRQ_BITS : stat_ff;
        nxt_stat[STAT_DONE_BIT] = nxt_stat[STAT_DONE_BIT] | nxt_done;
        nxt_irq = |(nxt_stat & nxt_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            operand_a_result_ff <= RST_OPERAND_A; // [RL16]
            operand_b_ff <= RST_OPERAND_B;
            remainder_reg_ff <= RST_REMAINDER;
            mul_not_div_select_ff <= RST_MODE;
            arith_run_enable_ff <= 1'b0;
            cnt_ff <= 6'h00;
            done_ff <= 1'b0;
            stat_ff <= RST_IRQ_BITS;
            mask_ff <= RST_IRQ_BITS;
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
            irq_ff <= 1'b0;
        end else begin
            operand_a_result_ff <= nxt_operand_a_result;
            operand_b_ff <= nxt_operand_b;
            remainder_reg_ff <= nxt_remainder_reg;
            mul_not_div_select_ff <= nxt_mul_not_div_select;
            arith_run_enable_ff <= nxt_arith_run_enable;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
            irq_ff <= nxt_irq;
        end
    end

    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign arith_done_irq = done_ff;
    assign irq_o = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Helper copies of the operands, read only by the checks below
    logic [31:0] chk_a_ff;
    logic [15:0] chk_b_ff;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            chk_a_ff <= 32'h0;
            chk_b_ff <= 16'h0;
        end else if (!arith_run_enable_ff && nxt_arith_run_enable) begin
            chk_a_ff <= nxt_operand_a_result;
            chk_b_ff <= nxt_operand_b;
        end
    end

    property p_mul_len;
        @(posedge clk_sys) disable iff (!resetn)
        ($rose(arith_run_enable_ff) && mul_not_div_select_ff) |-> cnt_ff == MUL_CYCLES;
    endproperty
    a_mul_len: assert property (p_mul_len) else $error("mul count wrong"); // [RL2]

    property p_div_len;
        @(posedge clk_sys) disable iff (!resetn)
        ($rose(arith_run_enable_ff) && !mul_not_div_select_ff) |-> cnt_ff == DIV_CYCLES;
    endproperty
    a_div_len: assert property (p_div_len) else $error("div count wrong"); // [RL8]

    property p_end_clear;
        @(posedge clk_sys) disable iff (!resetn)
        (arith_run_enable_ff && cnt_ff == 6'h01 && !abort)
            |=> (!arith_run_enable_ff && done_ff);
    endproperty
    a_end_clear: assert property (p_end_clear) else $error("enable not cleared"); // [RL5]

    property p_pulse;
        @(posedge clk_sys) disable iff (!resetn)
        done_ff |-> ($fell(arith_run_enable_ff) ##1 !done_ff);
    endproperty
    a_pulse: assert property (p_pulse) else $error("done pulse malformed"); // [RL15]

    property p_status;
        @(posedge clk_sys) disable iff (!resetn)
        done_ff |-> (stat_ff[STAT_DONE_BIT] && (irq_ff || !mask_ff[0]));
    endproperty
    a_status: assert property (p_status) else $error("done not flagged"); // [RL6]

    property p_hi_clear;
        @(posedge clk_sys) disable iff (!resetn)
        ($rose(arith_run_enable_ff) && mul_not_div_select_ff)
            |-> operand_a_result_ff[31:16] == 16'h0000;
    endproperty
    a_hi_clear: assert property (p_hi_clear) else $error("upper half not cleared"); // [RL12]

    property p_rem_clear;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(arith_run_enable_ff) |-> remainder_reg_ff == 16'h0000;
    endproperty
    a_rem_clear: assert property (p_rem_clear) else $error("remainder not cleared"); // [RL13]

    property p_abort;
        @(posedge clk_sys) disable iff (!resetn)
        abort |=> (!arith_run_enable_ff && !done_ff);
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored"); // [RL14]

    property p_mul_res;
        @(posedge clk_sys) disable iff (!resetn)
        (done_ff && mul_not_div_select_ff)
            |-> operand_a_result_ff == chk_a_ff[15:0] * chk_b_ff;
    endproperty
    a_mul_res: assert property (p_mul_res) else $error("bad product"); // [RL4]

    property p_div_res;
        @(posedge clk_sys) disable iff (!resetn)
        (done_ff && !mul_not_div_select_ff && chk_b_ff != 16'h0)
            |-> (48'(operand_a_result_ff) * 48'(chk_b_ff) + 48'(remainder_reg_ff)
                 == 48'(chk_a_ff) && remainder_reg_ff < chk_b_ff);
    endproperty
    a_div_res: assert property (p_div_res) else $error("bad quotient"); // [RL10]

endmodule : smd_mul_div_unit

// *** testbench/smd_cpu_model.sv ***
/*
 * CPU-side classic Wishbone master model for the multiply/divide unit.
 * Assumes a one-clock system with ack answered by the slave.
 */
`timescale 1ns/1ps

module smd_cpu_model (
    // Clock
    input wire logic clk_sys,
    // Wishbone master
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic wb_ack_i
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
    end

    // One classic cycle; waits for ack, the bench watchdog ends a hang
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_sys);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= 4'hf;
        wb_dat_o <= dat;
        do @(posedge clk_sys); while (wb_ack_i !== 1'b1);
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // Released data must not keep looking valid
        wb_dat_o <= ~dat;
    endtask : xfer
endmodule : smd_cpu_model

// *** testbench/smd_tb.sv ***
/*
 * Self-checking bench of the multiply/divide unit: register reads, timing
 * of the done pulse, interrupt status and mask, abort.
 * Assumes the CPU model drives the bus; a monitor checks every read answer.
 */
`timescale 1ns/1ps

module tb import smd_pkg::*;;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, arith_done_irq, irq_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [5:0] dq[$];
    logic [5:0] since = 6'h00;
    logic irq_en = 1'b1;
    int failures = 0;
    int tests_run = 0;

    always #10 clk_sys = ~clk_sys;

    smd_cpu_model u_cpu (.clk_sys(clk_sys), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
        .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i),
        .wb_ack_i(wb_ack_o));

    smd_mul_div_unit u_dut (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .arith_done_irq(arith_done_irq), .irq_o(irq_o));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp);
    endtask : chk_rd

    task automatic chk_done(input logic [5:0] got, input logic [5:0] exp);
        chk({26'h0, got}, {26'h0, exp});
    endtask : chk_done

    task automatic chk_irq(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_irq

    task automatic summarize();
        if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // Read answers and done pulses are checked against the oldest note
    always @(posedge clk_sys) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) chk(wb_dat_o, 32'hdead_beef);
            else chk_rd(wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
        end
        if (arith_done_irq === 1'b1) begin
            // A pulse with no note, as after an abort, is a mismatch
            if (dq.size() == 0) chk({26'h0, since}, 32'hffff_ffff);
            else chk_done(since, dq.pop_front());
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b1 && wb_adr_i == OFS_CONTROL) since <= 6'h00;
        else since <= since + 6'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        exp_q.push_back(exp);
        msk_q.push_back(msk);
        u_cpu.xfer(1'b0, adr, 32'h0000_0000);
    endtask : rd

    task automatic run_op(input logic mul, input logic [31:0] a, input logic [15:0] b);
        logic [31:0] res;
        logic [15:0] rem;
        res = mul ? a[15:0] * b : a / b;
        rem = mul ? 16'h0000 : 16'(a % b);
        u_cpu.xfer(1'b1, OFS_OPERAND_A, a);
        u_cpu.xfer(1'b1, OFS_OPERAND_B, {16'h0000, b});
        dq.push_back(mul ? MUL_CYCLES - 6'h01 : DIV_CYCLES - 6'h01);
        u_cpu.xfer(1'b1, OFS_CONTROL, {24'h0, 1'b1, 6'h00, mul});
        repeat (40) @(posedge clk_sys);
        #1 chk_irq(irq_o, irq_en);
        rd(OFS_OPERAND_A, res, 32'hffff_ffff);
        rd(OFS_REMAINDER, {16'h0, rem}, 32'h0000_ffff);
        rd(OFS_OPERAND_B, {16'h0, b}, 32'hffff_ffff);
        rd(OFS_CONTROL, 32'h0, 32'h80);
        rd(OFS_IRQ_STATUS, 32'h1, 32'h1);
        rd(OFS_IRQ_STATUS, 32'h0, 32'h1);
        @(posedge clk_sys);
        #1 chk_irq(irq_o, 1'b0);
    endtask : run_op

    initial begin
        void'($urandom(29));
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(OFS_OPERAND_A, 32'h0, 32'hffff_ffff);
        rd(OFS_REMAINDER, 32'h0, 32'hffff_ffff);
        rd(OFS_CONTROL, 32'h0, 32'hffff_ffff);
        rd(8'h1c, 32'h0, 32'hffff_ffff);
        u_cpu.xfer(1'b1, OFS_IRQ_MASK, 32'h1);
        rd(OFS_IRQ_MASK, 32'h1, 32'hffff_ffff);
        // Mode alone may be written while idle; it must not start a run
        u_cpu.xfer(1'b1, OFS_CONTROL, 32'h01);
        rd(OFS_CONTROL, 32'h01, 32'hffff_ffff);
        for (int i = 0; i < 4; i++) begin
            run_op(1'b0, $urandom(), 16'($urandom()) | 16'h0001);
            run_op(1'b1, $urandom(), 16'($urandom()));
        end
        // Masked: status still set, level interrupt stays low
        u_cpu.xfer(1'b1, OFS_IRQ_MASK, 32'h0);
        irq_en = 1'b0;
        rd(OFS_IRQ_MASK, 32'h0, 32'hffff_ffff);
        run_op(1'b1, 32'hffff_ffff, 16'hffff);
        // Abort mid-run: no pulse, no status
        u_cpu.xfer(1'b1, OFS_OPERAND_A, $urandom());
        u_cpu.xfer(1'b1, OFS_OPERAND_B, 32'h0000_0003);
        u_cpu.xfer(1'b1, OFS_CONTROL, 32'h80);
        repeat (5) @(posedge clk_sys);
        u_cpu.xfer(1'b1, OFS_CONTROL, 32'h00);
        repeat (40) @(posedge clk_sys);
        rd(OFS_CONTROL, 32'h0, 32'h80);
        rd(OFS_IRQ_STATUS, 32'h0, 32'h1);
        summarize();
    end

    // Whole run is under a thousand cycles
    initial begin
        #(20 * 20000);
        failures++;
        summarize();
    end
endmodule : tb
